// ==== hw/cisl_pkg.sv ====
// Purpose: constants and carriers of the channel interrupt status latch
// Assumes: word addressed Avalon-MM slave, twelve line channels
// Notes: word index = {block, register}; byte address is four times it
//
// What this block does
// [R1] fifo-limit change sets status bit 3, sticky
// [R2] lock-loss change sets status bit 2, sticky
// [R3] signal-loss change sets status bit 1, sticky
// [R4] drive-monitor change sets status bit 0, sticky
// [R5] status read returns bits then clears them
// [R6] zero bit means no change since read
// [R7] alarm register shows present condition levels
// [R8] twelve copies, register 2 of blocks 0-5, 8-d
// [R9] both declare and clear count as change
// [R10] enable bit one allows interrupt, zero blocks
// [R11] interrupt while enabled status bit set
package cisl_pkg;
  // channel count and per-channel field width
  localparam int CISL_CHANNELS = 12;
  localparam int CISL_COND_W = 4;
  // register index inside a channel block
  localparam logic [3:0] CISL_REG_ENABLE = 4'h1;
  localparam logic [3:0] CISL_REG_STATUS = 4'h2;
  localparam logic [3:0] CISL_REG_ALARM = 4'h3;
  // block numbers in use: 0-5 then 8-d, the gap of two is skipped
  localparam logic [3:0] CISL_BLK_LOW_MAX = 4'h5;
  localparam logic [3:0] CISL_BLK_HIGH_MIN = 4'h8;
  localparam logic [3:0] CISL_BLK_HIGH_MAX = 4'hd;
  localparam logic [3:0] CISL_BLK_GAP = 4'h2;
  // field positions inside status, enable and alarm registers
  localparam int CISL_BIT_FL = 3;
  localparam int CISL_BIT_LOL = 2;
  localparam int CISL_BIT_LOS = 1;
  localparam int CISL_BIT_DMO = 0;
  // reset values
  localparam logic [3:0] CISL_STATUS_RST = 4'h0;
  localparam logic [3:0] CISL_ENABLE_RST = 4'h0;
  // cycles after reset before a change may be reported
  localparam logic [2:0] CISL_WARM_CYCLES = 3'h4;
  // one channel's four conditions, msb first as in the registers
  typedef struct packed {
    logic fifo_limit_alarm;
    logic receive_lock_loss;
    logic receive_signal_loss;
    logic transmit_drive_monitor;
  } cisl_cond_s;
  // avalon request group driven by the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } cisl_avs_req_s;
  // bus slave states
  typedef enum logic {CISL_IDLE, CISL_DONE} cisl_bus_e;
endpackage

// ==== hw/cisl_top.sv ====
// Purpose: per-channel change-of-condition status latch with clear on read
// Assumes: condition inputs are asynchronous pins; one 125 MHz clock
// Notes: every request is answered on the second edge after it rises
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
module cisl_top import cisl_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input cisl_avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input cisl_cond_s [CISL_CHANNELS-1:0] cond,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // sync chain and settled level per channel
  logic [CISL_CHANNELS-1:0][CISL_COND_W-1:0] s1_q, s2_q, s3_q, lvl_q;
  // sticky change flags and their enables
  logic [CISL_CHANNELS-1:0][CISL_COND_W-1:0] status_q, en_q;
  // one-cycle change events, next status values
  logic [CISL_CHANNELS-1:0][CISL_COND_W-1:0] evt, status_d, clr;
  // per-channel strobes from the bus
  logic [CISL_CHANNELS-1:0] wr_en, rd_st;
  // warm-up counter after reset
  logic [2:0] warm_q, warm_d;
  logic warm;
  // bus state and registered read data
  cisl_bus_e state_q, state_d;
  logic [31:0] rdata_q, rdata_d;
  // address decode
  // chan carries a valid flag above the channel index; regsel picks the
  // register inside the block
  logic [4:0] chan;
  logic [3:0] ch;
  logic [3:0] regsel;
  logic hit;
  logic acc;
  // interrupt request flop
  logic irq_q, irq_d;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // map block number to channel index; msb flags a used block
  // blocks 6, 7, e and f hold no channel: a read there returns zero and a
  // write is dropped, so a stray address never aliases onto a live channel
  // closing the gap with one subtraction is cheaper than a twelve-entry table
  function automatic logic [4:0] chan_of(input logic [3:0] blk);
    logic [4:0] r;
    r = '0;
    if (blk <= CISL_BLK_LOW_MAX) begin
      r = {1'b1, blk};
    end else if (blk >= CISL_BLK_HIGH_MIN && blk <= CISL_BLK_HIGH_MAX) begin
      r = {1'b1, blk - CISL_BLK_GAP}; // blocks 8-d carry channels 6-11 [R8]
    end
    return r;
  endfunction

  // hit also demands one of the three registers; anything else reads zero
  // decode is combinational on the held address
  always_comb begin
    chan = chan_of(avs_req.address[7:4]);
    ch = chan[3:0];
    regsel = avs_req.address[3:0];
    hit = chan[4] && (regsel == CISL_REG_ENABLE || regsel == CISL_REG_STATUS
          || regsel == CISL_REG_ALARM);
  end

  ////////////////////////////////////////////////////////////////////////
  // warm-up: no change is reported until the sync chain and level hold
  // real samples, so a condition present at reset is not a false event
  // limitation: a genuine change inside those first cycles is folded into
  // the starting level and never reported; software should read the alarm
  // register once after reset to learn where each condition stands

  always_comb begin
    warm_d = (warm_q == CISL_WARM_CYCLES) ? warm_q : warm_q + 3'h1;
    warm = (warm_q == CISL_WARM_CYCLES);
  end

  // count up once after reset, then stay
  always_ff @(posedge clk) begin
    if (rst) begin
      warm_q <= 3'h0;
    end else begin
      warm_q <= warm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: request taken in idle, answered one edge later
  // trade-off: one fixed wait state per access costs a cycle, but read data
  // then come straight from a flop and the clear-on-read strobe lines up with
  // the accept edge, where the master takes the word
  // the master may present its next request on the accept edge itself; it is
  // taken on the following edge, after the state has returned to idle

  // accept edge: waitrequest is low and the master samples it
  assign acc = (state_q == CISL_DONE);
  assign avs_waitrequest = !acc;
  assign avs_readdata = rdata_q;

  // next state and read data; the word is captured on the take edge so that
  // it stands unchanged through the accept cycle
  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    unique case (state_q)
      CISL_IDLE: begin
        if (avs_req.read || avs_req.write) begin
          state_d = CISL_DONE;
          rdata_d = 32'h0; // unmapped address and writes read zero
          if (avs_req.read && hit) begin
            unique case (regsel)
              CISL_REG_ENABLE: rdata_d = {28'h0, en_q[ch]};
              CISL_REG_STATUS: rdata_d = {28'h0, status_q[ch]}; // [R5]
              default: rdata_d = {28'h0, lvl_q[ch]}; // present levels [R7]
            endcase
          end
        end
      end
      CISL_DONE: begin
        state_d = CISL_IDLE; // master drops or renews its request
      end
    endcase
  end

  // bus state and read data flops; reset leaves the slave idle with
  // waitrequest high, so nothing is taken before the first edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CISL_IDLE;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel latch
  // each condition pin passes three flops; the first may go metastable, so
  // only the second and third are looked at, and a new level is taken only
  // while those two agree. a pulse shorter than about two cycles may thus be
  // lost, which is acceptable for slow alarm levels
  // hazard: a read and a fresh change can meet in one cycle; the clear mask
  // is the word handed out, so the new change survives the read

  genvar c;
  generate
    for (c = 0; c < CISL_CHANNELS; c++) begin : g_ch
      logic [CISL_COND_W-1:0] agree;
      logic [CISL_COND_W-1:0] lvl_d, en_d;

      // strobes at the accept edge for this channel's copy [R8]
      always_comb begin
        wr_en[c] = acc && avs_req.write && hit && ch == c
                   && regsel == CISL_REG_ENABLE && avs_req.byteenable[0];
        rd_st[c] = acc && avs_req.read && hit && ch == c
                   && regsel == CISL_REG_STATUS;
      end

      // a bit counts once the second and third stages agree
      always_comb begin
        agree = ~(s2_q[c] ^ s3_q[c]);
        lvl_d = (lvl_q[c] & ~agree) | (s2_q[c] & agree);
        // rising and falling both differ from the held level [R9]
        evt[c] = warm ? (agree & (s2_q[c] ^ lvl_q[c])) : '0;
      end

      // clear only what was handed out, so a change after the read
      // data was captured is still reported next time
      always_comb begin
        clr[c] = rd_st[c] ? rdata_q[CISL_COND_W-1:0] : '0; // [R5]
        // set wins over clear; bits map 3..0 to fl, lol, los, dmo
        status_d[c] = (status_q[c] & ~clr[c]) | evt[c]; // [R1] [R2] [R3] [R4] [R6]
        en_d = wr_en[c] ? avs_req.writedata[CISL_COND_W-1:0] : en_q[c]; // [R10]
      end

      // sync chain, level, status and enable flops of this channel
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q[c] <= '0;
          s2_q[c] <= '0;
          s3_q[c] <= '0;
          lvl_q[c] <= '0;
          status_q[c] <= CISL_STATUS_RST;
          en_q[c] <= CISL_ENABLE_RST;
        end else begin
          s1_q[c] <= cond[c]; // first stage feeds only the second
          s2_q[c] <= s1_q[c];
          s3_q[c] <= s2_q[c];
          lvl_q[c] <= lvl_d;
          status_q[c] <= status_d[c];
          en_q[c] <= en_d;
        end
      end

      // checks per channel
      a_fl_sets: assert property (@(posedge clk) disable iff (rst) // [R1]
        evt[c][CISL_BIT_FL] |=> status_q[c][CISL_BIT_FL])
        else $error("fifo limit change not latched");
      a_lol_holds: assert property (@(posedge clk) disable iff (rst) // [R2]
        status_q[c][CISL_BIT_LOL] && !rd_st[c] |=> status_q[c][CISL_BIT_LOL])
        else $error("lock loss flag dropped without read");
      a_los_cause: assert property (@(posedge clk) disable iff (rst) // [R3]
        $rose(status_q[c][CISL_BIT_LOS]) |-> $past(evt[c][CISL_BIT_LOS]))
        else $error("signal loss flag set without change");
      a_dmo_sets: assert property (@(posedge clk) disable iff (rst) // [R4]
        evt[c][CISL_BIT_DMO] ##1 !rd_st[c] |-> status_q[c][CISL_BIT_DMO])
        else $error("drive monitor change not latched");
      a_read_clears: assert property (@(posedge clk) disable iff (rst) // [R5]
        rd_st[c] && evt[c] == '0 |=> (status_q[c] & $past(rdata_q[3:0])) == '0)
        else $error("status read did not clear bits");
      a_zero_stays: assert property (@(posedge clk) disable iff (rst) // [R6]
        ##1 (status_q[c] & ~$past(status_q[c]) & ~$past(evt[c])) == '0)
        else $error("status bit set with no change");
      a_alarm_level: assert property (@(posedge clk) disable iff (rst) // [R7]
        warm && s2_q[c] == s3_q[c] |=> lvl_q[c] == $past(s3_q[c]))
        else $error("alarm level not following settled input");
      a_both_edges: assert property (@(posedge clk) disable iff (rst || !warm) // [R9]
        ##1 $past(warm) && $changed(lvl_q[c]) |->
          ((status_q[c] & (lvl_q[c] ^ $past(lvl_q[c]))) ==
           (lvl_q[c] ^ $past(lvl_q[c]))))
        else $error("level change missed a status bit");
      // no bit falls without a status read of this channel
      a_bits_hold: assert property (@(posedge clk) disable iff (rst) // [R1] [R4]
        !rd_st[c] |=> (status_q[c] & $past(status_q[c])) == $past(status_q[c]))
        else $error("status bit dropped without read");
      // nothing new is reported while the chain is still warming up
      a_warm_quiet: assert property (@(posedge clk) disable iff (rst) // [R6]
        !warm |=> (status_q[c] & ~$past(status_q[c])) == '0)
        else $error("status bit set during warm-up");
      // enable bits move only on a write to this channel's copy
      a_enable_holds: assert property (@(posedge clk) disable iff (rst) // [R10]
        !wr_en[c] |=> en_q[c] == $past(en_q[c]))
        else $error("enable changed without write");
      a_enable_loads: assert property (@(posedge clk) disable iff (rst) // [R10]
        wr_en[c] |=> en_q[c] == $past(avs_req.writedata[CISL_COND_W-1:0]))
        else $error("enable write not taken");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupt request: any status bit whose enable is set
  // the request looks at the next status value, so it rises on the same edge
  // as the status bit and falls on the very accept edge of the clearing read
  // the pin itself comes from a flop so that decode glitches never reach it

  always_comb begin
    irq_d = 1'b0;
    for (int i = 0; i < CISL_CHANNELS; i++) begin
      irq_d = irq_d | (|(status_d[i] & en_q[i])); // [R10] [R11]
    end
  end

  // register the request; reset holds it low
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // the pin is the flop itself
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // bus and interrupt checks
  // these watch the slave from the bus side; they rely on a master that holds
  // its request until the accept edge, as the avalon rules require

  a_bus_answer: assert property (@(posedge clk) disable iff (rst) // [R8]
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst) // [R10]
    irq |-> $past(en_q) != '0)
    else $error("interrupt raised with all enables clear");
  a_irq_release: assert property (@(posedge clk) disable iff (rst) // [R11]
    ##1 irq == ($past(status_d & en_q) != '0))
    else $error("interrupt out of step with enabled status");
  // an unused block answers zero, and the spare upper bits always read zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // [R8]
    acc && avs_req.read && !hit |-> avs_readdata == 32'h0)
    else $error("unmapped block returned data");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst) // [R5]
    acc |-> avs_readdata[31:CISL_COND_W] == 28'h0)
    else $error("reserved read bits not zero");
  // one transfer touches at most one channel's copy
  a_strobe_onehot: assert property (@(posedge clk) disable iff (rst) // [R8]
    $onehot0({rd_st, wr_en}))
    else $error("strobes reached more than one channel");

  c_status_read: cover property (@(posedge clk) disable iff (rst)
    rd_st != '0 && rdata_q[3:0] != 4'h0);
  c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_irq_fall: cover property (@(posedge clk) disable iff (rst) $fell(irq));
  c_enable_write: cover property (@(posedge clk) disable iff (rst) wr_en != '0);
  // all four conditions reported by a single read
  c_four_changes: cover property (@(posedge clk) disable iff (rst)
    rd_st != '0 && rdata_q[3:0] == 4'hf);

endmodule

// ==== test/cisl_top_tb_top.sv ====
// Purpose: self-checking bench for the channel interrupt status latch
// Assumes: Avalon word index {block, register}; event edge shows 4 edges later
// Notes: reads note the expected word in a queue; a monitor compares on accept
module cisl_top_tb_top import cisl_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // 125 MHz
  logic rst = 1'b1; // synchronous, active high
  cisl_avs_req_s req; // bus request group
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  cisl_cond_s [CISL_CHANNELS-1:0] cond; // line conditions per channel
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] expq[$]; // expected read words, oldest first
  logic [3:0] blk; // block of the channel under test
  int rc;

  cisl_top dut_u (.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .cond(cond), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    // generous ceiling: the whole sequence needs about 470 cycles
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one Avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    if (!wr) expq.push_back(exp);
    // hold everything until the edge at which waitrequest is sampled low
    do @(posedge clk); while (wreq !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  // monitor: read data are taken at the accept edge, read up and waitrequest low
  always @(posedge clk) begin
    if (req.read === 1'b1 && wreq === 1'b0 && expq.size() > 0) begin
      check(rdata, expq.pop_front());
    end
  end

  // drive one condition bit and wait past the synchroniser
  task automatic flip(input int n, input int b, input logic v);
    @(posedge clk);
    cond[n][b] <= v;
    repeat (6) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    req = '0;
    cond = '0;
    void'($urandom(70));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    // reset values and an unmapped block
    bus(1'b0, 8'h01, 32'h0, 32'h0);
    bus(1'b0, 8'h02, 32'h0, 32'h0);
    bus(1'b0, 8'h03, 32'h0, 32'h0);
    bus(1'b0, 8'h62, 32'h0, 32'h0);
    // every channel: declare then clear one condition, reads clear the event
    for (int n = 0; n < CISL_CHANNELS; n++) begin
      blk = (n < 6) ? 4'(n) : 4'(n + 2);
      for (int e = 0; e < 2; e++) begin
        flip(n, n % 4, (e == 0));
        bus(1'b0, {blk, CISL_REG_ALARM}, 32'h0, (e == 0) ? 32'h1 << (n % 4) : 32'h0);
        bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'h1 << (n % 4));
        bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'h0);
      end
    end
    // interrupt gating on a random channel: only lock-loss enabled
    rc = $urandom_range(11, 0);
    blk = (rc < 6) ? 4'(rc) : 4'(rc + 2);
    bus(1'b1, {blk, CISL_REG_ENABLE}, 32'h4, 32'h0);
    bus(1'b0, {blk, CISL_REG_ENABLE}, 32'h0, 32'h4);
    flip(rc, CISL_BIT_DMO, 1'b1);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'h1);
    flip(rc, CISL_BIT_LOL, 1'b1);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'h4);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    // disabled again: the event is latched but raises no request
    bus(1'b1, {blk, CISL_REG_ENABLE}, 32'h0, 32'h0);
    flip(rc, CISL_BIT_LOL, 1'b0);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    // all four changes at once; writing status must not clear it
    @(posedge clk);
    cond[rc] <= 4'he; // was 4'h1, so every bit flips
    repeat (6) @(posedge clk);
    bus(1'b1, {blk, CISL_REG_STATUS}, 32'hf, 32'h0);
    bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'hf);
    bus(1'b0, {blk, CISL_REG_ALARM}, 32'h0, 32'he);
    bus(1'b0, {blk, CISL_REG_STATUS}, 32'h0, 32'h0);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
